// *** design/tsm_regs.svh ***
// timing constants and reset values of the transceiver system mode controller
`ifndef TSM_REGS_SVH
`define TSM_REGS_SVH

// clock period of ref_clk
`define TSM_CLK_NS 20

// supply undervoltage detection and recovery times
`define TSM_UNDERVOLT_DETECT_TIME_NS 20000
`define TSM_UNDERVOLT_RECOVER_TIME_NS 20000
`define TSM_T_LONG_UV_NS 100000000
`define TSM_DET_UV_CYC ((`TSM_UNDERVOLT_DETECT_TIME_NS + `TSM_CLK_NS - 1) / `TSM_CLK_NS)
`define TSM_REC_UV_CYC ((`TSM_UNDERVOLT_RECOVER_TIME_NS + `TSM_CLK_NS - 1) / `TSM_CLK_NS)
`define TSM_LONG_UV_CYC ((`TSM_T_LONG_UV_NS + `TSM_CLK_NS - 1) / `TSM_CLK_NS)

// boot delay after battery recovery
`define TSM_T_STARTUP_NS 1000000
`define TSM_STARTUP_CYC ((`TSM_T_STARTUP_NS + `TSM_CLK_NS - 1) / `TSM_CLK_NS)

// go-to-sleep hold time
`define TSM_T_GOTOSLEEP_NS 20000
`define TSM_GOTOSLEEP_CYC ((`TSM_T_GOTOSLEEP_NS + `TSM_CLK_NS - 1) / `TSM_CLK_NS)

// delay of diagnostic output after a mode change
`define TSM_T_ERR_DLY_NS 1000
`define TSM_ERR_DLY_CYC ((`TSM_T_ERR_DLY_NS + `TSM_CLK_NS - 1) / `TSM_CLK_NS)

// least phase length of the bus wake pattern
`define TSM_T_WUP_PHASE_NS 500
`define TSM_WUP_PHASE_CYC ((`TSM_T_WUP_PHASE_NS + `TSM_CLK_NS - 1) / `TSM_CLK_NS)

// reset values
`define TSM_RST_CNT 24'h00_0000
`define TSM_RST_PHASE 2'h0

`endif

// *** design/tsm_pkg.sv ***
// types of the transceiver system mode controller
package tsm_pkg;

  typedef logic [23:0] tsm_cnt_t;

  // one-hot system operating modes
  typedef enum logic [5:0] {
    TSM_OFF    = 6'h01,
    TSM_BOOT   = 6'h02,
    TSM_STBY   = 6'h04,
    TSM_NORM   = 6'h08,
    TSM_LISTEN = 6'h10,
    TSM_SLEEP  = 6'h20
  } tsm_mode_e;

  // one-hot bus-side modes
  typedef enum logic [5:0] {
    TSM_CAN_OFF     = 6'h01,
    TSM_CAN_OFFLINE = 6'h02,
    TSM_CAN_WAKE    = 6'h04,
    TSM_CAN_PASS    = 6'h08,
    TSM_CAN_ACTIVE  = 6'h10,
    TSM_CAN_LISTEN  = 6'h20
  } tsm_can_e;

  // supply status, battery, core and i/o
  typedef struct packed {
    logic bat;
    logic core;
    logic io;
  } tsm_supply_s;

  // two-way pin as level and enable
  typedef struct packed {
    logic out;
    logic oe;
  } tsm_pin_s;

endpackage : tsm_pkg

// *** design/tsm_uv_filter.sv ***
// supply undervoltage filter with long undervoltage timer
`timescale 1ns/100ps
`default_nettype none
`include "tsm_regs.svh"

module tsm_uv_filter #(
  parameter tsm_pkg::tsm_cnt_t DET_CYC = 24'(`TSM_DET_UV_CYC),
  parameter tsm_pkg::tsm_cnt_t REC_CYC = 24'(`TSM_REC_UV_CYC),
  parameter tsm_pkg::tsm_cnt_t LONG_CYC = 24'(`TSM_LONG_UV_CYC)
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic raw_ok,
  output logic ok,
  output logic uv_long
);

  tsm_pkg::tsm_cnt_t cnt;
  tsm_pkg::tsm_cnt_t low_cnt;

  // level flips only after the opposite level has held long enough
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ok <= 1'b0;
      cnt <= `TSM_RST_CNT;
    end else if (clk_en) begin
      if (raw_ok == ok) begin
        cnt <= `TSM_RST_CNT;
      end else if (cnt >= (ok ? DET_CYC : REC_CYC) - 24'h00_0001) begin
        ok <= raw_ok;
        cnt <= `TSM_RST_CNT;
      end else begin
        cnt <= cnt + 24'h00_0001;
      end
    end
  end

  // time spent in undervoltage, saturating
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      low_cnt <= `TSM_RST_CNT;
      uv_long <= 1'b0;
    end else if (clk_en) begin
      if (ok) begin
        low_cnt <= `TSM_RST_CNT;
        uv_long <= 1'b0;
      end else if (low_cnt != LONG_CYC) begin
        low_cnt <= low_cnt + 24'h00_0001;
      end else begin
        uv_long <= 1'b1;
      end
    end
  end

endmodule // tsm_uv_filter
`default_nettype wire

// *** design/tsm_ctrl.sv ***
// system and bus-side mode state machines of the transceiver
// How it works
// - battery undervoltage forces Off from any mode
// - after reset every supply reads absent, so the machine starts in Off
// - Off releases regulator switch and fault output
// - battery recovery runs boot delay, then Standby with regulator switch high
// - Standby with i/o present goes Normal or Listen-only by standby-select and enable
// - Standby enters Sleep on long i/o or core undervoltage
// - standby-select low, enable high held long enough requests Sleep from Standby
// - a set wake flag overrules the go-to-sleep request
// - both pins high with battery and i/o present selects Normal, switch high
// - standby-select high, enable low selects Listen-only: receive only, switch high
// - long core undervoltage sends Standby, Normal and Listen-only to Sleep
// - Sleep acts as Standby but releases the regulator switch
// - wake flag or standby-select rise with i/o present leaves Sleep
// - core and i/o present without go-to-sleep command leaves Sleep
// - Standby after Sleep proceeds by pin levels when standby-select high
// - mode changes at once; diagnostics appear after a delay
// - undervoltage and recovery are both filtered by hold times
// - separate bus-side machine follows system mode and core supply
// - receive data held low after a wake-up request
// - bus wake pattern phases above least filter time, battery only needed
// - three flags, one shown on fault output chosen by mode
// - Standby or Sleep: receive data low with wake flag, high without
// - wake flag set by wake-ups or power-on, cleared entering Normal
`timescale 1ns/100ps
`default_nettype none
`include "tsm_regs.svh"

module tsm_ctrl #(
  parameter tsm_pkg::tsm_cnt_t LONG_UV_CYC = 24'(`TSM_LONG_UV_CYC),
  parameter tsm_pkg::tsm_cnt_t STARTUP_CYC = 24'(`TSM_STARTUP_CYC)
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire tsm_pkg::tsm_supply_s supply_raw,
  input wire logic standby_select_n,
  input wire logic enable_pin,
  input wire logic txd,
  input wire logic local_wake,
  input wire logic bus_dominant,
  output tsm_pkg::tsm_pin_s regulator_switch_out,
  output tsm_pkg::tsm_pin_s fault_n,
  output tsm_pkg::tsm_pin_s rxd,
  output logic tx_enable,
  output logic rx_enable,
  output tsm_pkg::tsm_mode_e sys_mode,
  output tsm_pkg::tsm_can_e can_mode
);

  localparam tsm_pkg::tsm_cnt_t GTS_CYC = 24'(`TSM_GOTOSLEEP_CYC);
  localparam tsm_pkg::tsm_cnt_t ERR_DLY_CYC = 24'(`TSM_ERR_DLY_CYC);
  localparam logic [7:0] WUP_CYC = 8'(`TSM_WUP_PHASE_CYC);

  tsm_pkg::tsm_supply_s sup_ok;
  tsm_pkg::tsm_supply_s sup_long;
  tsm_pkg::tsm_mode_e next_mode;
  tsm_pkg::tsm_can_e next_can;
  tsm_pkg::tsm_cnt_t boot_cnt;
  tsm_pkg::tsm_cnt_t gts_cnt;
  tsm_pkg::tsm_cnt_t mode_age;
  logic stb_s1, stb_s2, stb_prev, en_s1, en_s2;
  logic stb_rise, gts_done, gts_flag;
  logic pwon, wake_flag, wake_src, wake_set, pwon_set;
  logic local_prev, local_edge, remote_wake, bus_prev, txd_armed;
  logic [7:0] run_cnt;
  logic [1:0] wup_phase;

  function automatic logic low_power(input tsm_pkg::tsm_mode_e m);
    low_power = (m == tsm_pkg::TSM_STBY) || (m == tsm_pkg::TSM_SLEEP);
  endfunction

  function automatic tsm_pkg::tsm_mode_e pin_mode(input logic en);
    pin_mode = en ? tsm_pkg::TSM_NORM : tsm_pkg::TSM_LISTEN;
  endfunction

  // supply filters, battery long timer left unused
  tsm_uv_filter #(.LONG_CYC(LONG_UV_CYC)) u_bat (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .raw_ok(supply_raw.bat), .ok(sup_ok.bat), .uv_long(sup_long.bat));
  tsm_uv_filter #(.LONG_CYC(LONG_UV_CYC)) u_core (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .raw_ok(supply_raw.core), .ok(sup_ok.core), .uv_long(sup_long.core));
  tsm_uv_filter #(.LONG_CYC(LONG_UV_CYC)) u_io (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .raw_ok(supply_raw.io), .ok(sup_ok.io), .uv_long(sup_long.io));

  // control pin synchronisers and edge history
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stb_s1 <= 1'b0;
      stb_s2 <= 1'b0;
      stb_prev <= 1'b0;
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
    end else if (clk_en) begin
      stb_s1 <= standby_select_n;
      stb_s2 <= stb_s1;
      stb_prev <= stb_s2;
      en_s1 <= enable_pin;
      en_s2 <= en_s1;
    end
  end

  assign stb_rise = stb_s2 && !stb_prev;

  // system next-mode decision
  always_comb begin
    next_mode = sys_mode;
    if (!sup_ok.bat) begin
      next_mode = tsm_pkg::TSM_OFF;
    end else begin
      case (sys_mode)
        tsm_pkg::TSM_OFF: begin
          next_mode = tsm_pkg::TSM_BOOT;
        end
        tsm_pkg::TSM_BOOT: begin
          if (boot_cnt >= STARTUP_CYC - 24'h00_0001) begin
            next_mode = tsm_pkg::TSM_STBY;
          end
        end
        tsm_pkg::TSM_STBY: begin
          if (sup_long.core || sup_long.io) begin
            next_mode = tsm_pkg::TSM_SLEEP;
          end else if (gts_done && !wake_flag) begin
            next_mode = tsm_pkg::TSM_SLEEP;
          end else if (sup_ok.io && stb_s2) begin
            next_mode = pin_mode(en_s2);
          end
        end
        tsm_pkg::TSM_NORM, tsm_pkg::TSM_LISTEN: begin
          if (sup_long.core) begin
            next_mode = tsm_pkg::TSM_SLEEP;
          end else if (!sup_ok.io || !stb_s2) begin
            next_mode = tsm_pkg::TSM_STBY;
          end else begin
            next_mode = pin_mode(en_s2);
          end
        end
        tsm_pkg::TSM_SLEEP: begin
          if (wake_flag || (stb_rise && sup_ok.io)) begin
            next_mode = tsm_pkg::TSM_STBY;
          end else if (sup_ok.core && sup_ok.io && !gts_flag) begin
            next_mode = tsm_pkg::TSM_STBY;
          end
        end
        default: begin
          next_mode = tsm_pkg::TSM_OFF;
        end
      endcase
    end
  end

  // system mode register, change takes effect at once
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sys_mode <= tsm_pkg::TSM_OFF;
    end else if (clk_en) begin
      sys_mode <= next_mode;
    end
  end

  // boot delay counter
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      boot_cnt <= `TSM_RST_CNT;
    end else if (clk_en) begin
      if (sys_mode == tsm_pkg::TSM_BOOT) begin
        boot_cnt <= boot_cnt + 24'h00_0001;
      end else begin
        boot_cnt <= `TSM_RST_CNT;
      end
    end
  end

  // go-to-sleep hold timer and command memory
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gts_cnt <= `TSM_RST_CNT;
      gts_flag <= 1'b0;
    end else if (clk_en) begin
      if (sys_mode == tsm_pkg::TSM_STBY && !stb_s2 && en_s2) begin
        if (!gts_done) begin
          gts_cnt <= gts_cnt + 24'h00_0001;
        end
      end else begin
        gts_cnt <= `TSM_RST_CNT;
      end
      if (sys_mode == tsm_pkg::TSM_STBY && gts_done && !wake_flag) begin
        gts_flag <= 1'b1;
      end else if (sys_mode != tsm_pkg::TSM_SLEEP) begin
        gts_flag <= 1'b0;
      end
    end
  end

  assign gts_done = (gts_cnt >= GTS_CYC);

  // local wake edge and bus wake pattern detector
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      local_prev <= 1'b0;
      bus_prev <= 1'b0;
      run_cnt <= 8'h00;
      wup_phase <= `TSM_RST_PHASE;
    end else if (clk_en) begin
      local_prev <= local_wake;
      bus_prev <= bus_dominant;
      if (bus_dominant != bus_prev) begin
        run_cnt <= 8'h00;
      end else if (run_cnt < WUP_CYC - 8'h01) begin
        run_cnt <= run_cnt + 8'h01;
      end
      if (!low_power(sys_mode) || remote_wake) begin
        wup_phase <= `TSM_RST_PHASE;
      end else if (bus_dominant != bus_prev) begin
        if (run_cnt < WUP_CYC - 8'h01) begin
          wup_phase <= `TSM_RST_PHASE;
        end else if (bus_prev && wup_phase == 2'h0) begin
          wup_phase <= 2'h1;
        end else if (!bus_prev && wup_phase == 2'h1) begin
          wup_phase <= 2'h2;
        end
      end
    end
  end

  assign local_edge = local_wake && !local_prev;
  assign remote_wake = low_power(sys_mode) && wup_phase == 2'h2 && bus_dominant &&
                       bus_prev && run_cnt == WUP_CYC - 8'h01;

  // power-on, wake and wake-source flags, a set wins over a clear
  assign pwon_set = (sys_mode == tsm_pkg::TSM_OFF) && (next_mode == tsm_pkg::TSM_BOOT);
  assign wake_set = remote_wake || local_edge || pwon_set;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pwon <= 1'b0;
      wake_flag <= 1'b0;
      wake_src <= 1'b0;
    end else if (clk_en) begin
      if (pwon_set) begin
        pwon <= 1'b1;
      end else if (next_mode == tsm_pkg::TSM_NORM && sys_mode != tsm_pkg::TSM_NORM) begin
        pwon <= 1'b0;
      end
      if (wake_set) begin
        wake_flag <= 1'b1;
      end else if (next_mode == tsm_pkg::TSM_NORM && sys_mode != tsm_pkg::TSM_NORM) begin
        wake_flag <= 1'b0;
      end
      if (local_edge || pwon_set) begin
        wake_src <= 1'b1;
      end else if (sys_mode == tsm_pkg::TSM_NORM && next_mode != tsm_pkg::TSM_NORM) begin
        wake_src <= 1'b0;
      end
    end
  end

  // time since the last mode change, saturating
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_age <= `TSM_RST_CNT;
    end else if (clk_en) begin
      if (next_mode != sys_mode) begin
        mode_age <= `TSM_RST_CNT;
      end else if (mode_age < ERR_DLY_CYC) begin
        mode_age <= mode_age + 24'h00_0001;
      end
    end
  end

  // regulator switch, released in off, boot and sleep
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regulator_switch_out <= '0;
    end else if (clk_en) begin
      regulator_switch_out.out <= 1'b1;
      regulator_switch_out.oe <= !(next_mode == tsm_pkg::TSM_OFF ||
                                   next_mode == tsm_pkg::TSM_BOOT ||
                                   next_mode == tsm_pkg::TSM_SLEEP);
    end
  end

  // fault output shows the flag chosen by the mode after the delay
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fault_n <= '0;
    end else if (clk_en) begin
      fault_n.oe <= sup_ok.io && !(sys_mode == tsm_pkg::TSM_OFF ||
                                   sys_mode == tsm_pkg::TSM_BOOT);
      if (mode_age < ERR_DLY_CYC) begin
        fault_n.out <= 1'b1;
      end else begin
        case (sys_mode)
          tsm_pkg::TSM_STBY, tsm_pkg::TSM_SLEEP: fault_n.out <= !wake_flag;
          tsm_pkg::TSM_LISTEN: fault_n.out <= !pwon;
          tsm_pkg::TSM_NORM: fault_n.out <= !wake_src;
          default: fault_n.out <= 1'b1;
        endcase
      end
    end
  end

  // bus-side machine from system mode and its own view of the core supply
  always_comb begin
    case (sys_mode)
      tsm_pkg::TSM_STBY, tsm_pkg::TSM_SLEEP: begin
        next_can = wake_flag ? tsm_pkg::TSM_CAN_WAKE : tsm_pkg::TSM_CAN_OFFLINE;
      end
      tsm_pkg::TSM_NORM: begin
        next_can = sup_ok.core ? tsm_pkg::TSM_CAN_ACTIVE : tsm_pkg::TSM_CAN_PASS;
      end
      tsm_pkg::TSM_LISTEN: begin
        next_can = sup_ok.core ? tsm_pkg::TSM_CAN_LISTEN : tsm_pkg::TSM_CAN_PASS;
      end
      default: begin
        next_can = tsm_pkg::TSM_CAN_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      can_mode <= tsm_pkg::TSM_CAN_OFF;
    end else if (clk_en) begin
      can_mode <= next_can;
    end
  end

  // receive data, transmitter and receiver enables
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxd <= '0;
      tx_enable <= 1'b0;
      rx_enable <= 1'b0;
      txd_armed <= 1'b0;
    end else if (clk_en) begin
      rxd.oe <= (can_mode != tsm_pkg::TSM_CAN_OFF);
      case (can_mode)
        tsm_pkg::TSM_CAN_OFFLINE: rxd.out <= 1'b1;
        tsm_pkg::TSM_CAN_WAKE: rxd.out <= 1'b0;
        tsm_pkg::TSM_CAN_OFF: rxd.out <= 1'b1;
        default: rxd.out <= !bus_dominant;
      endcase
      // transmitter waits for one recessive txd after entering active
      if (can_mode != tsm_pkg::TSM_CAN_ACTIVE) begin
        txd_armed <= 1'b0;
      end else if (txd) begin
        txd_armed <= 1'b1;
      end
      tx_enable <= (can_mode == tsm_pkg::TSM_CAN_ACTIVE) && (txd_armed || txd);
      rx_enable <= (can_mode == tsm_pkg::TSM_CAN_ACTIVE) ||
                   (can_mode == tsm_pkg::TSM_CAN_LISTEN) ||
                   (can_mode == tsm_pkg::TSM_CAN_PASS);
    end
  end

  // checks next to the logic
  property p_off_on_bat;
    @(posedge ref_clk) disable iff (sys_rst)
      (clk_en && !sup_ok.bat) |=> (sys_mode == tsm_pkg::TSM_OFF);
  endproperty
  a_off_on_bat: assert property (p_off_on_bat) else $error("no off on battery loss");

  property p_switch_released;
    @(posedge ref_clk) disable iff (sys_rst)
      (sys_mode == tsm_pkg::TSM_OFF || sys_mode == tsm_pkg::TSM_SLEEP) |->
        !regulator_switch_out.oe;
  endproperty
  a_switch_released: assert property (p_switch_released) else $error("switch driven");

  property p_switch_high;
    @(posedge ref_clk) disable iff (sys_rst)
      (sys_mode == tsm_pkg::TSM_STBY || sys_mode == tsm_pkg::TSM_NORM ||
       sys_mode == tsm_pkg::TSM_LISTEN) |-> (regulator_switch_out.oe && regulator_switch_out.out);
  endproperty
  a_switch_high: assert property (p_switch_high) else $error("switch not high");

  property p_boot_length;
    @(posedge ref_clk) disable iff (sys_rst)
      (sys_mode == tsm_pkg::TSM_STBY && $past(sys_mode) == tsm_pkg::TSM_BOOT) |->
        ($past(boot_cnt) == STARTUP_CYC - 24'h00_0001);
  endproperty
  a_boot_length: assert property (p_boot_length) else $error("boot delay wrong");

  property p_normal_select;
    @(posedge ref_clk) disable iff (sys_rst)
      (clk_en && sys_mode == tsm_pkg::TSM_STBY && sup_ok.bat && sup_ok.io && stb_s2 && en_s2 &&
       !sup_long.core && !gts_done) |=> (sys_mode == tsm_pkg::TSM_NORM);
  endproperty
  a_normal_select: assert property (p_normal_select) else $error("normal not selected");

  property p_wake_blocks_sleep;
    @(posedge ref_clk) disable iff (sys_rst)
      (clk_en && sys_mode == tsm_pkg::TSM_STBY && wake_flag && !sup_long.core &&
       !sup_long.io) |=> (sys_mode != tsm_pkg::TSM_SLEEP);
  endproperty
  a_wake_blocks_sleep: assert property (p_wake_blocks_sleep) else $error("sleep despite wake");

  property p_stb_rise_exit;
    @(posedge ref_clk) disable iff (sys_rst)
      (clk_en && sys_mode == tsm_pkg::TSM_SLEEP && sup_ok.bat && stb_rise && sup_ok.io) |=>
        (sys_mode == tsm_pkg::TSM_STBY);
  endproperty
  a_stb_rise_exit: assert property (p_stb_rise_exit) else $error("sleep not left");

  property p_err_delay;
    @(posedge ref_clk) disable iff (sys_rst)
      ($past(clk_en) && !$past(sys_rst) && $past(mode_age) < ERR_DLY_CYC) |-> fault_n.out;
  endproperty
  a_err_delay: assert property (p_err_delay) else $error("diagnostic too early");

  property p_rxd_wake;
    @(posedge ref_clk) disable iff (sys_rst)
      ($past(clk_en) && $past(can_mode) == tsm_pkg::TSM_CAN_WAKE) |-> (rxd.oe && !rxd.out);
  endproperty
  a_rxd_wake: assert property (p_rxd_wake) else $error("rxd not low on wake");

  property p_wake_cleared;
    @(posedge ref_clk) disable iff (sys_rst)
      ($rose(sys_mode == tsm_pkg::TSM_NORM) && !$past(wake_set)) |-> !wake_flag;
  endproperty
  a_wake_cleared: assert property (p_wake_cleared) else $error("wake flag kept");

endmodule // tsm_ctrl
`default_nettype wire

// *** dv/tsm_host_model.sv ***
// host model driving the mode-select pins of the transceiver
`timescale 1ns/100ps
`default_nettype none

module tsm_host_model (
  input wire logic ref_clk,
  input wire logic [1:0] cmd,
  output var logic standby_select_n = 1'b0,
  output var logic enable_pin = 1'b0
);
  // requests: 0 standby, 1 normal, 2 listen-only, 3 go-to-sleep held as long as cmd stays
  always @(negedge ref_clk) begin
    standby_select_n <= cmd[0] ^ cmd[1];
    enable_pin <= cmd[0];
  end
endmodule // tsm_host_model

`default_nettype wire

// *** dv/transceiver_system_mode_controller_tb.sv ***
// self-checking testbench of the transceiver system mode controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) chk((a) === (b))

module transceiver_system_mode_controller_tb;
  logic ref_clk, sys_rst, clk_en, txd, local_wake, bus_dominant;
  logic standby_select_n, enable_pin, tx_enable, rx_enable;
  logic [1:0] cmd;
  tsm_pkg::tsm_supply_s supply_raw;
  tsm_pkg::tsm_pin_s regulator_switch_out, fault_n, rxd;
  tsm_pkg::tsm_mode_e sys_mode;
  tsm_pkg::tsm_can_e can_mode;
  int num_errors = 0;
  int comparisons = 0;

  // free-running 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // long counts shortened to keep the run brief
  tsm_ctrl #(.LONG_UV_CYC(24'h00_0028), .STARTUP_CYC(24'h00_0014)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .supply_raw(supply_raw),
    .standby_select_n(standby_select_n), .enable_pin(enable_pin), .txd(txd),
    .local_wake(local_wake), .bus_dominant(bus_dominant),
    .regulator_switch_out(regulator_switch_out), .fault_n(fault_n), .rxd(rxd),
    .tx_enable(tx_enable), .rx_enable(rx_enable), .sys_mode(sys_mode), .can_mode(can_mode)
  );

  tsm_host_model i_host (
    .ref_clk(ref_clk), .cmd(cmd), .standby_select_n(standby_select_n), .enable_pin(enable_pin)
  );

  task automatic chk(input bit ok);
    comparisons++;
    if (!ok) begin
      num_errors++;
      $display("BAD %0t unexpected value", $time);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // bounded wait for a mode, then compare
  task automatic wait_mode(input tsm_pkg::tsm_mode_e m, input int lim);
    int n;
    n = 0;
    while (sys_mode !== m && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(sys_mode, m);
  endtask

  // bus wake pattern with phases of len cycles
  task automatic bus_wake_pattern(input int len);
    bus_dominant = 1'b1;
    cyc(len);
    bus_dominant = 1'b0;
    cyc(len);
    bus_dominant = 1'b1;
    cyc(len);
    bus_dominant = 1'b0;
    cyc(4);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic t_cold;
    `CHK(sys_mode, tsm_pkg::TSM_OFF);
    `CHK({regulator_switch_out.oe, fault_n.oe}, 2'h0);
  endtask

  task automatic t_boot;
    supply_raw = 3'h7;
    cyc(990);
    `CHK(sys_mode, tsm_pkg::TSM_OFF);
    wait_mode(tsm_pkg::TSM_BOOT, 20);
    wait_mode(tsm_pkg::TSM_STBY, 40);
    cyc(5);
    `CHK(regulator_switch_out, 2'h3);
    `CHK(fault_n, 2'h3);
    `CHK(can_mode, tsm_pkg::TSM_CAN_WAKE);
    `CHK(rxd, 2'h1);
    cyc(60);
    `CHK(fault_n, 2'h1);
  endtask

  task automatic t_pins;
    cmd = 2'h1;
    wait_mode(tsm_pkg::TSM_NORM, 10);
    cyc(4);
    `CHK({tx_enable, rx_enable, regulator_switch_out.oe}, 3'h7);
    `CHK(can_mode, tsm_pkg::TSM_CAN_ACTIVE);
    // clock enable low freezes the mode despite a new pin request
    clk_en = 1'b0;
    cmd = 2'h2;
    cyc(10);
    `CHK(sys_mode, tsm_pkg::TSM_NORM);
    clk_en = 1'b1;
    wait_mode(tsm_pkg::TSM_LISTEN, 10);
    cyc(4);
    `CHK({tx_enable, rx_enable, regulator_switch_out.oe}, 3'h3);
    cmd = 2'h0;
    wait_mode(tsm_pkg::TSM_STBY, 10);
    cyc(4);
    `CHK(rxd, 2'h3);
    local_wake = 1'b1;
    cyc(4);
    `CHK(can_mode, tsm_pkg::TSM_CAN_WAKE);
  endtask

  task automatic t_sleep;
    cmd = 2'h3;
    local_wake = 1'b0;
    cyc(1100);
    `CHK(sys_mode, tsm_pkg::TSM_STBY);
    cmd = 2'h1;
    wait_mode(tsm_pkg::TSM_NORM, 10);
    cmd = 2'h3;
    wait_mode(tsm_pkg::TSM_STBY, 10);
    cyc(990);
    `CHK(sys_mode, tsm_pkg::TSM_STBY);
    wait_mode(tsm_pkg::TSM_SLEEP, 20);
    cyc(3);
    `CHK(regulator_switch_out.oe, 1'b0);
    cmd = 2'h1;
    wait_mode(tsm_pkg::TSM_NORM, 20);
  endtask

  task automatic t_uv;
    supply_raw.core = 1'b0;
    wait_mode(tsm_pkg::TSM_SLEEP, 1100);
    supply_raw.core = 1'b1;
    wait_mode(tsm_pkg::TSM_NORM, 1100);
    cmd = 2'h0;
    wait_mode(tsm_pkg::TSM_STBY, 10);
    supply_raw.io = 1'b0;
    wait_mode(tsm_pkg::TSM_SLEEP, 1100);
    bus_wake_pattern(20);
    `CHK(can_mode, tsm_pkg::TSM_CAN_OFFLINE);
    bus_wake_pattern(30);
    `CHK(can_mode, tsm_pkg::TSM_CAN_WAKE);
    supply_raw.bat = 1'b0;
    wait_mode(tsm_pkg::TSM_OFF, 1100);
    cyc(4);
    `CHK({regulator_switch_out.oe, fault_n.oe, rxd.oe}, 3'h0);
  endtask

  // main sequence
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    txd = 1'b1;
    local_wake = 1'b0;
    bus_dominant = 1'b0;
    cmd = 2'h0;
    supply_raw = 3'h0;
    cyc(16);
    sys_rst = 1'b0;
    cyc(2);
    t_cold();
    t_boot();
    t_pins();
    t_sleep();
    t_uv();
    give_verdict();
  end

  // watchdog against a hang
  initial begin
    cyc(20000);
    num_errors++;
    give_verdict();
  end
endmodule // transceiver_system_mode_controller_tb

`default_nettype wire
